//--- nps_slices.sv
// Page engine and result registers for the parity slices of a NAND page.
// Function
// R1: Software copies each slice's parity into spare area after writing page.
// R2: Single error on read reports the flipped bit's offset in its byte.
// R3: Single error on read reports the faulty byte's index in the slice.
// R4: With multiple errors the location fields mean nothing; software ignores them.
// R5: Slices 5, 6, 7 cover bytes 1280-1535, 1536-1791, 1792-2047.
// R6: Slices 8, 9, 10 cover bytes 2048-2303, 2304-2559, 2560-2815.
// R7: One code per 256 bytes over 512, 2048 or 4096 byte pages.
// R8: Slice word: offset 2:0, index 10:3, zero 11, parity 22:12, zero above.
//
// The register offsets and the strobed register port were left to the implementer.
`include "nps_cfg.svh"

module nps_slices #(
  parameter int FIRST_SLICE = `NPS_FIRST_SLICE
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_page_start,
  input wire logic i_data_valid,
  input wire logic [7:0] i_data,
  output logic [31:0] o_rdata,
  output logic o_irq
);

  // ********************************
  // Elaboration checks
  // ********************************

  // The sixteen sectors of a 4096 byte page bound the slice window.
  if (FIRST_SLICE < 0 || FIRST_SLICE + `NPS_NUM_SLICES > 16) begin : g_chk
    $error("FIRST_SLICE puts slices beyond a 4096 byte page");
  end

  // ********************************
  // State and helpers
  // ********************************

  nps_pkg::nps_regs_t r_reg;
  nps_pkg::nps_regs_t r_next;

  logic sec_end;
  logic in_rng;
  logic [2:0] rel;
  logic [10:0] code_new;
  logic par_new;
  logic [10:0] syn;
  logic pd;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [4:0] sec_no;
  logic [4:0] ref_no;

  nps_calc_if cif ();

  // The calculator sees the incoming byte and its index in the sector.
  assign cif.byte_in = i_data;
  assign cif.idx = r_reg.cnt[7:0];

  nps_bitcode u_bitcode (
    .c(cif.calc)
  );

  // ********************************
  // Next state
  // ********************************

  // All block state moves through one copy; bus, engine and events merge here.
  always_comb begin
    r_next = r_reg;
    ev = 3'h0;
    clr = 3'h0;
    sec_end = 1'b0;
    code_new = r_reg.acc ^ cif.contrib;
    par_new = r_reg.par ^ cif.bpar;
    // Sector number of the current byte picks the slice. [R5] [R6]
    sec_no = {1'b0, r_reg.cnt[11:8]};
    in_rng = (sec_no >= 5'(FIRST_SLICE))
      && (sec_no < 5'(FIRST_SLICE + `NPS_NUM_SLICES));
    // Outside the window the slot is parked at zero so no lookup runs off the table.
    rel = in_rng ? 3'(sec_no - 5'(FIRST_SLICE)) : 3'h0;
    syn = code_new ^ r_reg.refc[rel][10:0];
    pd = par_new ^ r_reg.refc[rel][`NPS_REF_PAR];
    ref_no = 5'(i_wdata[`NPS_REF_SLOT_LO+3:`NPS_REF_SLOT_LO]) - 5'(FIRST_SLICE);

    // Register writes; slice words have no write path at all. [R8]
    if (i_wr) begin
      case (i_addr)
        `NPS_OFS_CTRL: begin
          r_next.ctrl = i_wdata[2:0];
        end
        `NPS_OFS_MASK: begin
          r_next.mask = i_wdata[2:0];
        end
        `NPS_OFS_STAT: begin
          clr = i_wdata[2:0];
        end
        `NPS_OFS_REF: begin
          // Stored code read back from spare area, one slice at a time.
          if (ref_no < 5'(`NPS_NUM_SLICES)) begin
            r_next.refc[3'(ref_no)] = i_wdata[11:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Page engine.
    case (r_reg.st)
      nps_pkg::NPS_IDLE: begin
        if (i_page_start) begin
          r_next.st = nps_pkg::NPS_RUN;
          r_next.cnt = 12'h0;
          r_next.acc = 11'h0;
          r_next.par = 1'b0;
        end
      end
      nps_pkg::NPS_RUN: begin
        if (i_page_start) begin
          // A new page abandons the one in flight.
          r_next.cnt = 12'h0;
          r_next.acc = 11'h0;
          r_next.par = 1'b0;
        end else if (i_data_valid) begin
          r_next.cnt = r_reg.cnt + 12'h1;
          r_next.acc = code_new;
          r_next.par = par_new;
          // Every 256th byte closes one code. [R7]
          if (r_reg.cnt[7:0] == 8'hff) begin
            sec_end = 1'b1;
            r_next.acc = 11'h0;
            r_next.par = 1'b0;
            if (in_rng) begin
              r_next.ppar[rel] = par_new;
              if (!r_reg.ctrl[`NPS_CTRL_RDMODE]) begin
                // Write pass: inverse parity for software to save. [R1]
                r_next.slice[rel] = nps_pkg::pack_slice(~code_new, 11'h0);
              end else if (pd) begin
                // Odd parity change: one flipped bit, syndrome locates it. [R2] [R3]
                r_next.slice[rel] = nps_pkg::pack_slice(~code_new, syn);
                ev[`NPS_EV_SINGLE] = 1'b1;
              end else if (syn != 11'h0) begin
                // Even change but nonzero syndrome: location is unusable. [R4]
                r_next.slice[rel] = nps_pkg::pack_slice(~code_new, 11'h0);
                ev[`NPS_EV_MULTI] = 1'b1;
              end else begin
                r_next.slice[rel] = nps_pkg::pack_slice(~code_new, 11'h0);
              end
            end
          end
          // The size code sets where the page ends. [R7]
          if (r_reg.cnt == nps_pkg::page_last(r_reg.ctrl[2:1])) begin
            r_next.st = nps_pkg::NPS_DONE;
          end
        end
      end
      nps_pkg::NPS_DONE: begin
        ev[`NPS_EV_DONE] = 1'b1;
        r_next.st = nps_pkg::NPS_IDLE;
      end
      default: begin
        r_next.st = nps_pkg::NPS_IDLE;
      end
    endcase

    // Sticky events; a new event wins over a clear in the same cycle.
    r_next.stat = (r_reg.stat & ~clr) | ev;
    r_next.irq = |(r_next.stat & r_next.mask);

    // Read data stand one cycle after the strobe, zero otherwise.
    r_next.rdata = 32'h0;
    if (i_rd) begin
      if (i_addr[7:5] == 3'h0 && i_addr[1:0] == 2'h0
          && i_addr[4:2] < 3'(`NPS_NUM_SLICES)) begin
        r_next.rdata = r_reg.slice[i_addr[4:2]];
      end else begin
        case (i_addr)
          `NPS_OFS_CTRL: r_next.rdata = {29'h0, r_reg.ctrl};
          `NPS_OFS_STAT: r_next.rdata = {29'h0, r_reg.stat};
          `NPS_OFS_MASK: r_next.rdata = {29'h0, r_reg.mask};
          `NPS_OFS_PPAR: r_next.rdata = {25'h0, r_reg.ppar};
          default: r_next.rdata = 32'h0;
        endcase
      end
    end
  end

  // ********************************
  // Registers
  // ********************************

  // Synchronous reset: results clear, engine idles, nothing pending.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      r_reg <= '0;
      r_reg.st <= nps_pkg::NPS_IDLE;
      r_reg.ctrl <= `NPS_CTRL_RST;
      r_reg.mask <= `NPS_MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;
  assign o_irq = r_reg.irq;

  // ********************************
  // Assertions
  // ********************************

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // A sector closing inside the window during a read pass.
  sequence s_sec_rd;
    sec_end && in_rng && r_reg.ctrl[`NPS_CTRL_RDMODE];
  endsequence

  sequence s_single;
    s_sec_rd ##0 pd;
  endsequence

  property p_bit_ofs;
    s_single |=> r_reg.slice[$past(rel)][2:0] == $past(syn[2:0]);
  endproperty
  a_bit_ofs: assert property (p_bit_ofs) // [R2]
    else $error("bit offset differs from syndrome");

  property p_byte_idx;
    s_single |=> r_reg.slice[$past(rel)][10:3] == $past(syn[10:3])
      && r_reg.stat[`NPS_EV_SINGLE];
  endproperty
  a_byte_idx: assert property (p_byte_idx) // [R3]
    else $error("byte index differs from syndrome");

  property p_multi;
    s_sec_rd ##0 (!pd && syn != 11'h0) |=> r_reg.stat[`NPS_EV_MULTI]
      && r_reg.slice[$past(rel)][10:0] == 11'h0;
  endproperty
  a_multi: assert property (p_multi) // [R4]
    else $error("multiple error not flagged");

  property p_slice5;
    sec_end && r_reg.cnt[11:8] == 4'h5 && FIRST_SLICE == 5
      |=> r_reg.slice[0][22:12] == ~$past(code_new);
  endproperty
  a_slice5: assert property (p_slice5) // [R5]
    else $error("sector five not held in first slice");

  property p_slice8;
    sec_end && r_reg.cnt[11:8] == 4'h8 && FIRST_SLICE == 5
      |=> r_reg.slice[3][22:12] == ~$past(code_new);
  endproperty
  a_slice8: assert property (p_slice8) // [R6]
    else $error("sector eight not held in fourth slice");

  property p_sector;
    i_data_valid && r_reg.st == nps_pkg::NPS_RUN && !i_page_start
      |-> sec_end == (r_reg.cnt[7:0] == 8'hff) ##1 (!$past(sec_end) || r_reg.acc == 11'h0);
  endproperty
  a_sector: assert property (p_sector) // [R7]
    else $error("sector boundary not at 256 bytes");

  property p_page_end;
    r_reg.st == nps_pkg::NPS_DONE
      |-> $past(r_reg.cnt) == nps_pkg::page_last(r_reg.ctrl[2:1])
      ##1 r_reg.stat[`NPS_EV_DONE] && r_reg.st == nps_pkg::NPS_IDLE;
  endproperty
  a_page_end: assert property (p_page_end) // [R7]
    else $error("page did not end at its size");

  property p_layout;
    r_reg.slice[0][31:23] == 9'h0 && r_reg.slice[0][11] == 1'b0
      && r_reg.slice[6][31:23] == 9'h0 && r_reg.slice[6][11] == 1'b0;
  endproperty
  a_layout: assert property (p_layout) // [R8]
    else $error("reserved slice bits not zero");

  property p_ro;
    i_wr && i_addr == `NPS_OFS_SLICE && !sec_end |=> $stable(r_reg.slice);
  endproperty
  a_ro: assert property (p_ro) // [R8]
    else $error("slice register changed on a bus write");

  property p_rdata;
    i_rd && i_addr == `NPS_OFS_STAT ##1 !i_rd
      |-> o_rdata == {29'h0, $past(r_reg.stat)} ##1 o_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("status read data misplaced");

  property p_irq;
    o_irq == |(r_reg.stat & r_reg.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow masked status");

  // ********************************
  // Engine bookkeeping assertions
  // ********************************

  // A sector closing inside the window during a write pass.
  sequence s_sec_wr;
    sec_end && in_rng && !r_reg.ctrl[`NPS_CTRL_RDMODE];
  endsequence

  // Software saves the whole word, so stale location bits would corrupt the spare area.
  property p_wr_loc;
    s_sec_wr |=> r_reg.slice[$past(rel)][10:0] == 11'h0;
  endproperty
  a_wr_loc: assert property (p_wr_loc) // [R1]
    else $error("write pass left a location in a slice");

  property p_clean;
    s_sec_rd ##0 (!pd && syn == 11'h0) |=> r_reg.slice[$past(rel)][10:0] == 11'h0;
  endproperty
  a_clean: assert property (p_clean) // [R2]
    else $error("clean sector reported a location");

  // A skipped or doubled byte would shift every later sector boundary.
  property p_count;
    i_data_valid && r_reg.st == nps_pkg::NPS_RUN && !i_page_start
      |=> r_reg.cnt == $past(r_reg.cnt) + 12'h1;
  endproperty
  a_count: assert property (p_count) // [R7]
    else $error("byte counter did not step by one");

  property p_ppar;
    sec_end && in_rng |=> r_reg.ppar[$past(rel)] == $past(par_new);
  endproperty
  a_ppar: assert property (p_ppar) // [R7]
    else $error("overall parity not kept at sector close");

  // The saved code must land in the slot that its slice number names.
  property p_ref;
    i_wr && i_addr == `NPS_OFS_REF && ref_no < 5'(`NPS_NUM_SLICES)
      |=> r_reg.refc[$past(ref_no[2:0])] == $past(i_wdata[11:0]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("stored code not kept in its slot");

  property p_idle;
    r_reg.st == nps_pkg::NPS_IDLE && !i_page_start
      |=> r_reg.st == nps_pkg::NPS_IDLE && $stable(r_reg.cnt);
  endproperty
  a_idle: assert property (p_idle)
    else $error("engine left idle without a page start");

endmodule

//--- nps_cfg.svh
// Offsets, field positions, reset values and counts of the parity slices.
`ifndef NPS_CFG_SVH
`define NPS_CFG_SVH

// ********************************
// Register offsets
// ********************************
`define NPS_OFS_SLICE 8'h00
`define NPS_OFS_CTRL 8'h20
`define NPS_OFS_STAT 8'h24
`define NPS_OFS_MASK 8'h28
`define NPS_OFS_REF 8'h2c
`define NPS_OFS_PPAR 8'h30

// ********************************
// Field positions
// ********************************
`define NPS_CTRL_RDMODE 0
`define NPS_CTRL_SIZE_LO 1
`define NPS_REF_PAR 11
`define NPS_REF_SLOT_LO 16
`define NPS_EV_DONE 0
`define NPS_EV_SINGLE 1
`define NPS_EV_MULTI 2

// ********************************
// Reset values and counts
// ********************************
`define NPS_CTRL_RST 3'h0
`define NPS_MASK_RST 3'h0
`define NPS_SEC_BYTES 256
`define NPS_FIRST_SLICE 5
`define NPS_NUM_SLICES 7
`define NPS_LAST_512 12'h1ff
`define NPS_LAST_2048 12'h7ff
`define NPS_LAST_4096 12'hfff

`endif

//--- nps_pkg.sv
// Types and helpers shared by the parity slice files.
`include "nps_cfg.svh"

package nps_pkg;

  // One-hot page engine states.
  typedef enum logic [2:0] {
    NPS_IDLE = 3'b001,
    NPS_RUN = 3'b010,
    NPS_DONE = 3'b100
  } nps_fsm_t;

  // Whole state of the slice block.
  typedef struct packed {
    nps_fsm_t st;
    logic [11:0] cnt;
    logic [10:0] acc;
    logic par;
    logic [`NPS_NUM_SLICES-1:0][31:0] slice;
    logic [`NPS_NUM_SLICES-1:0][11:0] refc;
    logic [`NPS_NUM_SLICES-1:0] ppar;
    logic [2:0] ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic irq;
  } nps_regs_t;

  // Builds a slice word; bit 11 and bits 31:23 stay zero.
  function automatic logic [31:0] pack_slice(input logic [10:0] inv,
                                             input logic [10:0] loc);
    pack_slice = {9'h0, inv, 1'b0, loc};
  endfunction

  // Last byte index of a page for the size code.
  function automatic logic [11:0] page_last(input logic [1:0] sz);
    case (sz)
      2'h0: page_last = `NPS_LAST_512;
      2'h1: page_last = `NPS_LAST_2048;
      default: page_last = `NPS_LAST_4096;
    endcase
  endfunction

endpackage

//--- nps_calc_if.sv
// Link between the page engine and the per-byte code calculator.
interface nps_calc_if;
  logic [7:0] byte_in;
  logic [7:0] idx;
  logic [10:0] contrib;
  logic bpar;
  modport eng (output byte_in, output idx, input contrib, input bpar);
  modport calc (input byte_in, input idx, output contrib, output bpar);
endinterface

//--- nps_bitcode.sv
// Code contribution of one data byte at a given index inside its sector.
module nps_bitcode (
  nps_calc_if.calc c
);

  // Each set bit adds its location {byte index, bit number} by XOR.
  always_comb begin
    logic [2:0] col;
    col = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (c.byte_in[i]) begin
        col = col ^ 3'(i);
      end
    end
    c.bpar = ^c.byte_in;
    c.contrib = {(c.bpar ? c.idx : 8'h0), col};
  end

endmodule

//--- nps_nand_model.sv
// Behavioural NAND flash that streams one stored page into the slice block.
module nps_nand_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [12:0] i_nbytes,
  output logic o_page_start,
  output logic o_data_valid,
  output logic [7:0] o_data,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  logic [7:0] flip [4096];
  // Bytes leave in page order, 8 bits wide, with random idle gaps when slow.
  // A release inverts the bus, so stale data never match except after a gap on the last byte.
  initial begin
    o_page_start = 1'b0;
    o_data_valid = 1'b0;
    o_data = 8'h00;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_page_start <= 1'b1;
        @(posedge i_clk);
        o_page_start <= 1'b0;
        for (int p = 0; p < i_nbytes; p++) begin
          o_data_valid <= 1'b1;
          o_data <= mem[p] ^ flip[p];
          @(posedge i_clk);
          if (i_slow && $urandom_range(2) == 0) begin
            o_data_valid <= 1'b0;
            o_data <= ~o_data;
            @(posedge i_clk);
          end
        end
        o_data_valid <= 1'b0;
        o_data <= ~o_data;
        o_busy <= 1'b0;
      end
    end
  end
endmodule

//--- nps_slices_tb_top.sv
// Self-checking bench for the parity slice block.
module nps_slices_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Wiring
  // ********
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [12:0] nbytes = 13'h0;
  logic pstart, dvalid, busy, irq;
  logic [7:0] dbyte;
  logic [31:0] rdata;
  logic [10:0] exp_loc [7];
  logic [11:0] c;
  int bad_count = 0;
  int compares = 0;
  // Clock of 10 ns period.
  always #5 clk = ~clk;
  nps_slices i_nps_slices (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .i_page_start(pstart), .i_data_valid(dvalid),
    .i_data(dbyte), .o_rdata(rdata), .o_irq(irq));
  nps_nand_model i_nps_nand_model (.i_clk(clk), .i_go(go), .i_slow(slow), .i_nbytes(nbytes),
    .o_page_start(pstart), .o_data_valid(dvalid), .o_data(dbyte), .o_busy(busy));
  // ********
  // Helpers
  // ********
  // Code of a stored sector with its overall parity on top; each set bit adds one.
  function automatic logic [11:0] sec_code(input int s);
    logic [11:0] r;
    r = 12'h0;
    for (int i = 0; i < 256; i++)
      for (int b = 0; b < 8; b++)
        if (i_nps_nand_model.mem[s * 256 + i][b])
          r ^= {1'b1, 8'(i), 3'(b)};
    return r;
  endfunction
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A write takes one cycle; an idle edge follows so strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  // Read data are sampled mid-cycle, the only cycle where they stand.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
    @(posedge clk);
  endtask
  // Stream one page under a bounded wait, then allow the done flag to land.
  task automatic run_page(input logic [31:0] ctrl, input logic [12:0] n, input logic s);
    int w;
    w = 0;
    wr(8'h20, ctrl);
    nbytes <= n;
    slow <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0 && w < 20000) begin
      @(posedge clk);
      w++;
    end
    if (w >= 20000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t page stuck", $time);
    end
    repeat (4) @(posedge clk);
  endtask
  // Read back a 4096 byte page with the planted flips and check every location.
  task automatic read_pass(input logic [31:0] st);
    for (int k = 0; k < 7; k++)
      if (exp_loc[k] != 11'h0)
        i_nps_nand_model.flip[(5 + k) * 256 + exp_loc[k][10:3]] ^= 8'h1 << exp_loc[k][2:0];
    run_page(32'h5, 13'h1000, 1'b1);
    for (int k = 0; k < 7; k++)
      rchk(8'(4 * k), 32'hff800fff, {21'h0, exp_loc[k]});
    rchk(8'h24, 32'h7, st);
    wr(8'h24, 32'h7);
    for (int i = 0; i < 4096; i++)
      i_nps_nand_model.flip[i] = 8'h00;
  endtask
  // Verdict.
  task automatic conclude();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  // The watchdog allows several times the expected run of about 20k cycles.
  initial begin
    #1000000;
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    conclude();
  end
  // Main sequence: reset values, write pass, saved codes, read passes, page sizes.
  initial begin
    void'($urandom(21));
    for (int i = 0; i < 4096; i++) begin
      i_nps_nand_model.mem[i] = 8'($urandom);
      i_nps_nand_model.flip[i] = 8'h00;
    end
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 7; k++)
      rchk(8'(4 * k), 32'hffffffff, 32'h0);
    rchk(8'h20, 32'hffffffff, 32'h0);
    rchk(8'h28, 32'hffffffff, 32'h0);
    rchk(8'h80, 32'hffffffff, 32'h0);
    wr(8'h00, 32'hffffffff);
    rchk(8'h00, 32'hffffffff, 32'h0);
    run_page(32'h6, 13'h1000, 1'b0); // Size code 3 also means a 4096 byte page.
    for (int k = 0; k < 7; k++) begin
      c = sec_code(5 + k);
      rchk(8'(4 * k), 32'hffffffff, {9'h0, ~c[10:0], 12'h0});
      rchk(8'h30, 32'h1 << k, {31'h0, c[11]} << k);
      wr(8'h2c, {12'h0, 4'(5 + k), 4'h0, c});
    end
    rchk(8'h24, 32'h7, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h28, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h24, 32'h7);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 7; k++)
      exp_loc[k] = {8'($urandom_range(255)), 3'($urandom_range(7))};
    exp_loc[0] = {8'h00, 3'h7};
    exp_loc[6] = {8'hff, 3'h0};
    read_pass(32'h3);
    for (int k = 0; k < 7; k++)
      exp_loc[k] = 11'h0;
    exp_loc[5] = {8'($urandom_range(255)), 3'($urandom_range(7))};
    i_nps_nand_model.flip[2048 + 3] = 8'h02;
    i_nps_nand_model.flip[2048 + 200] = 8'h20;
    read_pass(32'h7);
    for (int z = 0; z < 2; z++) begin
      run_page(32'(2 * z), 13'(512 << (2 * z)), z[0]);
      rchk(8'h24, 32'h1, 32'h1);
      wr(8'h24, 32'h7);
    end
    c = sec_code(7);
    rchk(8'h08, 32'hffffffff, {9'h0, ~c[10:0], 12'h0});
    conclude();
  end
endmodule
